// >>> hw/shared_pin_priority_mux.sv
/*
 Shared pin priority multiplexer for five general-purpose ports.
 Assumes peripherals and port logic run on clk_i and drive their claims,
 output values and enables synchronously; pads are resolved outside.
*/
`timescale 1ns/1ns
module shared_pin_priority_mux #(
   parameter int PINS = pin_mux_pkg::NUM_PINS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Serial pin location option
   input wire logic pin_location_config_option_i,
   // Port I/O requests and read-back
   input wire logic [PINS-1:0] gpio_out_i,
   input wire logic [PINS-1:0] gpio_oe_i,
   output logic [PINS-1:0] gpio_in_o,
   // Serial peripheral interface
   input wire logic spi_en_i,
   input wire pin_mux_pkg::spi_drive_type spi_drive_i,
   output pin_mux_pkg::spi_sense_type spi_sense_o,
   // Enhanced serial interface
   input wire logic esci_en_i,
   input wire logic esci_tx_i,
   output logic esci_rx_o,
   // Keyboard wakeup
   input wire logic [pin_mux_pkg::NUM_KBD-1:0] kbd_en_i,
   output logic [pin_mux_pkg::NUM_KBD-1:0] kbd_o,
   // Converter inputs
   input wire logic [pin_mux_pkg::NUM_ADC-1:0] adc_en_i,
   // Timer channels
   input wire logic [pin_mux_pkg::NUM_TIMER_CH-1:0] tima_en_i,
   input wire pin_mux_pkg::drive_type [pin_mux_pkg::NUM_TIMER_CH-1:0]
      tima_drive_i,
   output logic [pin_mux_pkg::NUM_TIMER_CH-1:0] tima_o,
   input wire logic [pin_mux_pkg::NUM_TIMER_CH-1:0] timb_en_i,
   input wire pin_mux_pkg::drive_type [pin_mux_pkg::NUM_TIMER_CH-1:0]
      timb_drive_i,
   output logic [pin_mux_pkg::NUM_TIMER_CH-1:0] timb_o,
   // Oscillator and bus clock out
   input wire logic osc_in_en_i,
   input wire logic osc_out_en_i,
   input wire logic osc_out_i,
   input wire logic mclk_en_i,
   input wire logic mclk_i,
   // Pads
   input wire logic [PINS-1:0] pad_i,
   output logic [PINS-1:0] pad_o,
   output logic [PINS-1:0] pad_oe_o
);

   pin_mux_pkg::func_req_type [pin_mux_pkg::NUM_SLOTS-1:0] req [PINS];
   logic [PINS-1:0] level;
   logic alt;
   logic spi_def;
   logic spi_alt;
   logic esci_def;
   logic esci_alt;
   logic [PINS-1:0] gpio_in;
   logic [PINS-1:0] next_gpio_in;
   pin_mux_pkg::spi_sense_type spi_sense;
   pin_mux_pkg::spi_sense_type next_spi_sense;
   logic esci_rx;
   logic next_esci_rx;
   logic [pin_mux_pkg::NUM_KBD-1:0] kbd;
   logic [pin_mux_pkg::NUM_KBD-1:0] next_kbd;
   logic [pin_mux_pkg::NUM_TIMER_CH-1:0] tima;
   logic [pin_mux_pkg::NUM_TIMER_CH-1:0] next_tima;
   logic [pin_mux_pkg::NUM_TIMER_CH-1:0] timb;
   logic [pin_mux_pkg::NUM_TIMER_CH-1:0] next_timb;

   function automatic pin_mux_pkg::func_req_type claim(
      input logic en,
      input logic out,
      input logic oe
   );
      pin_mux_pkg::func_req_type r;
      r.en = en;
      r.out = out;
      r.oe = oe;
      return r;
   endfunction

   // Only the chosen location may claim serial pads
   assign alt = pin_location_config_option_i == pin_mux_pkg::LOC_ALT;
   assign spi_def = spi_en_i && !alt;
   assign spi_alt = spi_en_i && alt;
   assign esci_def = esci_en_i && !alt;
   assign esci_alt = esci_en_i && alt;

   always_comb begin
      for (int p = 0; p < PINS; p++) begin
         req[p][pin_mux_pkg::SLOT_FIRST] = pin_mux_pkg::REQ_OFF;
         req[p][pin_mux_pkg::SLOT_SECOND] = pin_mux_pkg::REQ_OFF;
         // Port I/O always claims, so it only wins by default
         req[p][pin_mux_pkg::SLOT_GPIO] =
            claim(1'b1, gpio_out_i[p], gpio_oe_i[p]);
      end
      // Port A
      req[pin_mux_pkg::PIN_A6][pin_mux_pkg::SLOT_FIRST] =
         claim(spi_def, 1'b0, 1'b0);
      req[pin_mux_pkg::PIN_A5][pin_mux_pkg::SLOT_FIRST] =
         claim(spi_def, spi_drive_i.sck.out, spi_drive_i.sck.oe);
      req[pin_mux_pkg::PIN_A4][pin_mux_pkg::SLOT_FIRST] =
         claim(kbd_en_i[4], 1'b0, 1'b0);
      req[pin_mux_pkg::PIN_A3][pin_mux_pkg::SLOT_FIRST] =
         claim(esci_def, 1'b0, 1'b0);
      req[pin_mux_pkg::PIN_A3][pin_mux_pkg::SLOT_SECOND] =
         claim(kbd_en_i[3], 1'b0, 1'b0);
      req[pin_mux_pkg::PIN_A2][pin_mux_pkg::SLOT_FIRST] =
         claim(esci_def, esci_tx_i, 1'b1);
      req[pin_mux_pkg::PIN_A2][pin_mux_pkg::SLOT_SECOND] =
         claim(kbd_en_i[2], 1'b0, 1'b0);
      req[pin_mux_pkg::PIN_A1][pin_mux_pkg::SLOT_FIRST] =
         claim(kbd_en_i[1], 1'b0, 1'b0);
      req[pin_mux_pkg::PIN_A0][pin_mux_pkg::SLOT_FIRST] =
         claim(kbd_en_i[0], 1'b0, 1'b0);
      // Port B: converter inputs never drive the pad
      for (int i = 0; i < pin_mux_pkg::NUM_ADC; i++) begin
         req[pin_mux_pkg::PIN_B0 + i][pin_mux_pkg::SLOT_FIRST] =
            claim(adc_en_i[i], 1'b0, 1'b0);
      end
      req[pin_mux_pkg::PIN_B7][pin_mux_pkg::SLOT_SECOND] =
         claim(timb_en_i[1], timb_drive_i[1].out,
               timb_drive_i[1].oe);
      req[pin_mux_pkg::PIN_B6][pin_mux_pkg::SLOT_SECOND] =
         claim(timb_en_i[0], timb_drive_i[0].out,
               timb_drive_i[0].oe);
      req[pin_mux_pkg::PIN_B5][pin_mux_pkg::SLOT_SECOND] =
         claim(spi_alt, spi_drive_i.sck.out, spi_drive_i.sck.oe);
      req[pin_mux_pkg::PIN_B4][pin_mux_pkg::SLOT_SECOND] =
         claim(spi_alt, spi_drive_i.mosi.out, spi_drive_i.mosi.oe);
      req[pin_mux_pkg::PIN_B3][pin_mux_pkg::SLOT_SECOND] =
         claim(spi_alt, spi_drive_i.miso.out, spi_drive_i.miso.oe);
      // Port C
      req[pin_mux_pkg::PIN_C4][pin_mux_pkg::SLOT_FIRST] =
         claim(osc_in_en_i, 1'b0, 1'b0);
      req[pin_mux_pkg::PIN_C3][pin_mux_pkg::SLOT_FIRST] =
         claim(osc_out_en_i, osc_out_i, 1'b1);
      req[pin_mux_pkg::PIN_C2][pin_mux_pkg::SLOT_FIRST] =
         claim(mclk_en_i, mclk_i, 1'b1);
      req[pin_mux_pkg::PIN_C2][pin_mux_pkg::SLOT_SECOND] =
         claim(spi_alt, 1'b0, 1'b0);
      req[pin_mux_pkg::PIN_C1][pin_mux_pkg::SLOT_FIRST] =
         claim(spi_def, spi_drive_i.mosi.out, spi_drive_i.mosi.oe);
      req[pin_mux_pkg::PIN_C0][pin_mux_pkg::SLOT_FIRST] =
         claim(spi_def, spi_drive_i.miso.out, spi_drive_i.miso.oe);
      // Port D
      req[pin_mux_pkg::PIN_D1][pin_mux_pkg::SLOT_FIRST] =
         claim(tima_en_i[1], tima_drive_i[1].out,
               tima_drive_i[1].oe);
      req[pin_mux_pkg::PIN_D0][pin_mux_pkg::SLOT_FIRST] =
         claim(tima_en_i[0], tima_drive_i[0].out,
               tima_drive_i[0].oe);
      // Port E
      req[pin_mux_pkg::PIN_E1][pin_mux_pkg::SLOT_FIRST] =
         claim(esci_alt, 1'b0, 1'b0);
      req[pin_mux_pkg::PIN_E0][pin_mux_pkg::SLOT_FIRST] =
         claim(esci_alt, esci_tx_i, 1'b1);
   end

   for (genvar g = 0; g < PINS; g++) begin : g_pin
      pin_slot #(
         .SLOTS(pin_mux_pkg::NUM_SLOTS)
      ) u_slot (
         .clk_i(clk_i),
         .rst_n_i(rst_n_i),
         .req_i(req[g]),
         .pad_i(pad_i[g]),
         .pad_o(pad_o[g]),
         .pad_oe_o(pad_oe_o[g]),
         .level_o(level[g])
      );
   end

   // Sensed levels reach peripherals from the selected location only;
   // one extra register keeps every output straight from a flip-flop
   always_comb begin
      next_gpio_in = level;
      next_spi_sense.ss = alt ? level[pin_mux_pkg::PIN_C2] :
                                level[pin_mux_pkg::PIN_A6];
      next_spi_sense.sck = alt ? level[pin_mux_pkg::PIN_B5] :
                                 level[pin_mux_pkg::PIN_A5];
      next_spi_sense.mosi = alt ? level[pin_mux_pkg::PIN_B4] :
                                  level[pin_mux_pkg::PIN_C1];
      next_spi_sense.miso = alt ? level[pin_mux_pkg::PIN_B3] :
                                  level[pin_mux_pkg::PIN_C0];
      next_esci_rx = alt ? level[pin_mux_pkg::PIN_E1] :
                           level[pin_mux_pkg::PIN_A3];
      next_kbd = level[pin_mux_pkg::PIN_A4:pin_mux_pkg::PIN_A0];
      next_tima = level[pin_mux_pkg::PIN_D1:pin_mux_pkg::PIN_D0];
      next_timb = level[pin_mux_pkg::PIN_B7:pin_mux_pkg::PIN_B6];
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         gpio_in <= '0;
         spi_sense <= '0;
         esci_rx <= pin_mux_pkg::LEVEL_RESET;
         kbd <= '0;
         tima <= '0;
         timb <= '0;
      end else begin
         gpio_in <= next_gpio_in;
         spi_sense <= next_spi_sense;
         esci_rx <= next_esci_rx;
         kbd <= next_kbd;
         tima <= next_tima;
         timb <= next_timb;
      end
   end

   assign gpio_in_o = gpio_in;
   assign spi_sense_o = spi_sense;
   assign esci_rx_o = esci_rx;
   assign kbd_o = kbd;
   assign tima_o = tima;
   assign timb_o = timb;

endmodule

// >>> hw/pin_mux_pkg.sv
/*
 Shared constants and carrier types for the shared pin priority multiplexer.
 Assumes one 125 MHz clock domain on the logic side of the pins.
*/
package pin_mux_pkg;

   // Pad count and priority slots per pad, last slot is port I/O
   localparam int NUM_PINS = 24;
   localparam int NUM_SLOTS = 3;
   localparam int SLOT_FIRST = 0;
   localparam int SLOT_SECOND = 1;
   localparam int SLOT_GPIO = 2;
   localparam int SYNC_STAGES = 3;
   localparam int NUM_KBD = 5;
   localparam int NUM_ADC = 8;
   localparam int NUM_TIMER_CH = 2;

   // Pad indices in the flat pad vectors
   localparam int PIN_A0 = 0;
   localparam int PIN_A1 = 1;
   localparam int PIN_A2 = 2;
   localparam int PIN_A3 = 3;
   localparam int PIN_A4 = 4;
   localparam int PIN_A5 = 5;
   localparam int PIN_A6 = 6;
   localparam int PIN_B0 = 7;
   localparam int PIN_B1 = 8;
   localparam int PIN_B2 = 9;
   localparam int PIN_B3 = 10;
   localparam int PIN_B4 = 11;
   localparam int PIN_B5 = 12;
   localparam int PIN_B6 = 13;
   localparam int PIN_B7 = 14;
   localparam int PIN_C0 = 15;
   localparam int PIN_C1 = 16;
   localparam int PIN_C2 = 17;
   localparam int PIN_C3 = 18;
   localparam int PIN_C4 = 19;
   localparam int PIN_D0 = 20;
   localparam int PIN_D1 = 21;
   localparam int PIN_E0 = 22;
   localparam int PIN_E1 = 23;

   // Serial pin location choice
   localparam logic LOC_DEFAULT = 1'b0;
   localparam logic LOC_ALT = 1'b1;

   // Reset values
   localparam logic PAD_RESET = 1'b0;
   localparam logic OE_RESET = 1'b0;
   localparam logic LEVEL_RESET = 1'b0;

   // One claim on a pad: claim, output value, output enable
   typedef struct packed {
      logic en;
      logic out;
      logic oe;
   } func_req_type;

   typedef struct packed {
      logic out;
      logic oe;
   } drive_type;

   typedef struct packed {
      drive_type sck;
      drive_type mosi;
      drive_type miso;
   } spi_drive_type;

   typedef struct packed {
      logic ss;
      logic sck;
      logic mosi;
      logic miso;
   } spi_sense_type;

   localparam func_req_type REQ_OFF = '{en: 1'b0, out: 1'b0, oe: 1'b0};

endpackage

// >>> hw/pin_slot.sv
/*
 One shared pad: fixed-priority owner choice, registered drive, and a
 three-stage input synchroniser with agreement filter.
 Assumes slot 0 is the highest priority and the last slot always claims.
*/
`timescale 1ns/1ns
module pin_slot #(
   parameter int SLOTS = pin_mux_pkg::NUM_SLOTS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Claims, highest priority in slot 0
   input wire pin_mux_pkg::func_req_type [SLOTS-1:0] req_i,
   // Pad side
   input wire logic pad_i,
   output logic pad_o,
   output logic pad_oe_o,
   // Filtered pad level
   output logic level_o
);

   logic [pin_mux_pkg::SYNC_STAGES-1:0] sync;
   logic [pin_mux_pkg::SYNC_STAGES-1:0] next_sync;
   logic pad;
   logic next_pad;
   logic pad_oe;
   logic next_pad_oe;
   logic level;
   logic next_level;
   logic found;

   always_comb begin
      next_pad = pin_mux_pkg::PAD_RESET;
      next_pad_oe = pin_mux_pkg::OE_RESET;
      found = 1'b0;
      // First enabled claim wins the pad
      for (int k = 0; k < SLOTS; k++) begin
         if (!found && req_i[k].en) begin
            next_pad = req_i[k].out;
            next_pad_oe = req_i[k].oe;
            found = 1'b1;
         end
      end
      next_sync = {sync[pin_mux_pkg::SYNC_STAGES-2:0], pad_i};
      next_level = level;
      // Stage 0 feeds stage 1 only; stages 1 and 2 must agree
      if (sync[1] == sync[2]) begin
         next_level = sync[2];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sync <= '0;
         pad <= pin_mux_pkg::PAD_RESET;
         pad_oe <= pin_mux_pkg::OE_RESET;
         level <= pin_mux_pkg::LEVEL_RESET;
      end else begin
         sync <= next_sync;
         pad <= next_pad;
         pad_oe <= next_pad_oe;
         level <= next_level;
      end
   end

   assign pad_o = pad;
   assign pad_oe_o = pad_oe;
   assign level_o = level;

endmodule

// >>> sim/peri_model.sv
/*
 Peripheral and port-logic model feeding the multiplexer claims.
 Assumes the bench seeds $urandom and freezes values with hold_i.
*/
`timescale 1ns/1ns
module peri_model (
   // Clock and freeze
   input wire logic clk_i,
   input wire logic hold_i,
   // Values toward the multiplexer
   output logic [23:0] gpio_out_o,
   output logic [23:0] gpio_oe_o,
   output logic [16:0] drv_o
);
   // New values every cycle while hold_i is low, so a stale owner shows at once
   always @(negedge clk_i) begin
      if (!hold_i) begin
         gpio_out_o <= 24'($urandom);
         gpio_oe_o <= 24'($urandom);
         drv_o <= 17'($urandom);
      end
   end
endmodule

// >>> sim/shared_pin_priority_mux_checker.sv
/*
 Port-level checks for the shared pin multiplexer, bound below.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module shared_pin_priority_mux_checker #(
   parameter int PINS = 24
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Claims and values
   input wire logic pin_location_config_option_i,
   input wire logic [PINS-1:0] gpio_oe_i,
   input wire logic spi_en_i,
   input wire pin_mux_pkg::spi_drive_type spi_drive_i,
   input wire logic esci_en_i,
   input wire logic esci_tx_i,
   input wire logic [4:0] kbd_en_i,
   input wire logic [7:0] adc_en_i,
   input wire logic [1:0] tima_en_i,
   input wire pin_mux_pkg::drive_type [1:0] tima_drive_i,
   input wire logic mclk_en_i,
   input wire logic mclk_i,
   // Pad drive
   input wire logic [PINS-1:0] pad_o,
   input wire logic [PINS-1:0] pad_oe_o
);
   logic alt;
   assign alt = pin_location_config_option_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Serial claims only count at the selected location
   sequence tx_claim;
      esci_en_i && !alt;
   endsequence
   sequence reloc_clk;
      !adc_en_i[5] && spi_en_i && alt;
   endsequence
   chk_reset_undriven: assert property (disable iff (1'h0)
      !rst_n_i |=> pad_oe_o == '0 && pad_o == '0) else $error("reset drive");
   chk_gpio_last: assert property (!kbd_en_i[0] |=>
      pad_oe_o[0] == $past(gpio_oe_i[0])) else $error("A0 owner");
   chk_sck_default: assert property (spi_en_i && !alt |=>
      pad_oe_o[5] == $past(spi_drive_i.sck.oe)) else $error("A5 owner");
   chk_b5_reloc: assert property (reloc_clk |=>
      pad_oe_o[12] == $past(spi_drive_i.sck.oe)) else $error("B5 owner");
   chk_loc_unused: assert property (
      !adc_en_i[5] && !(spi_en_i && alt) |=>
      pad_oe_o[12] == $past(gpio_oe_i[12])) else $error("B5 port");
   chk_tima_claim: assert property (tima_en_i[1] |=>
      pad_oe_o[21] == $past(tima_drive_i[1].oe)) else $error("D1 owner");
   chk_adc_undriven: assert property (adc_en_i[2] |=> !pad_oe_o[9])
      else $error("B2 driven");
   chk_tx_drive: assert property (tx_claim |=> pad_oe_o[2]
      && pad_o[2] == $past(esci_tx_i)) else $error("A2 transmit");
   chk_rx_kbd: assert property (
      esci_en_i && !alt || kbd_en_i[3] |=> !pad_oe_o[3]) else $error("A3");
   chk_mclk_first: assert property (mclk_en_i |=> pad_oe_o[17]
      && pad_o[17] == $past(mclk_i)) else $error("C2 bus clock");
endmodule

bind shared_pin_priority_mux shared_pin_priority_mux_checker #(.PINS(PINS))
   i_checker (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .pin_location_config_option_i(pin_location_config_option_i),
   .gpio_oe_i(gpio_oe_i), .spi_en_i(spi_en_i), .spi_drive_i(spi_drive_i),
   .esci_en_i(esci_en_i), .esci_tx_i(esci_tx_i), .kbd_en_i(kbd_en_i),
   .adc_en_i(adc_en_i), .tima_en_i(tima_en_i), .tima_drive_i(tima_drive_i),
   .mclk_en_i(mclk_en_i), .mclk_i(mclk_i), .pad_o(pad_o),
   .pad_oe_o(pad_oe_o));

// >>> sim/shared_pin_priority_mux_tb_top.sv
/*
 Self-checking bench for the shared pin multiplexer.
 Assumes undriven pads take a random outside level.
*/
`timescale 1ns/1ns
module shared_pin_priority_mux_tb_top;
   logic clk_i, rst_n, alt, hold, rx;
   logic [21:0] en;
   logic [23:0] ext, x_oe, x_o, g_out, g_oe, g_in, pad_i, pad_o, pad_oe;
   logic [16:0] drv;
   logic [4:0] kbd;
   logic [1:0] ta, tb;
   pin_mux_pkg::spi_sense_type sense;
   logic [47:0] dq[$];
   logic [37:0] sq[$];
   int num_errors, checked, quiet;
   assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext);
   shared_pin_priority_mux i_shared_pin_priority_mux (.clk_i(clk_i),
      .rst_n_i(rst_n), .pin_location_config_option_i(alt),
      .gpio_out_i(g_out), .gpio_oe_i(g_oe), .gpio_in_o(g_in),
      .spi_en_i(en[21]), .spi_drive_i(drv[16:11]), .spi_sense_o(sense),
      .esci_en_i(en[20]), .esci_tx_i(drv[2]), .esci_rx_o(rx),
      .kbd_en_i(en[19:15]), .kbd_o(kbd), .adc_en_i(en[14:7]),
      .tima_en_i(en[6:5]), .tima_drive_i(drv[10:7]), .tima_o(ta),
      .timb_en_i(en[4:3]), .timb_drive_i(drv[6:3]), .timb_o(tb),
      .osc_in_en_i(en[2]), .osc_out_en_i(en[1]), .osc_out_i(drv[1]),
      .mclk_en_i(en[0]), .mclk_i(drv[0]), .pad_i(pad_i), .pad_o(pad_o),
      .pad_oe_o(pad_oe));
   peri_model i_peri_model (.clk_i(clk_i), .hold_i(hold),
      .gpio_out_o(g_out), .gpio_oe_o(g_oe), .drv_o(drv));
   function automatic void put(int p, logic [1:0] d);
      x_oe[p] = d[0];
      x_o[p] = d[1] & d[0];
   endfunction
   // Lowest priority first, so higher claims overwrite
   function automatic void build();
      x_oe = g_oe;
      x_o = g_out & g_oe;
      for (int i = 0; i < 5; i++)
         if (en[15+i]) put(i, 2'h0);
      if (en[21]) begin
         put(alt ? 17 : 6, 2'h0);
         put(alt ? 12 : 5, drv[16:15]);
         put(alt ? 11 : 16, drv[14:13]);
         put(alt ? 10 : 15, drv[12:11]);
      end
      if (en[20]) begin
         put(alt ? 23 : 3, 2'h0);
         put(alt ? 22 : 2, {drv[2], 1'h1});
      end
      for (int i = 0; i < 2; i++) begin
         if (en[5+i]) put(20+i, drv[7+2*i +: 2]);
         if (en[3+i]) put(13+i, drv[3+2*i +: 2]);
      end
      for (int i = 0; i < 8; i++)
         if (en[7+i]) put(7+i, 2'h0);
      if (en[2]) put(19, 2'h0);
      if (en[1]) put(18, {drv[1], 1'h1});
      if (en[0]) put(17, {drv[0], 1'h1});
      if (!rst_n) {x_oe, x_o} = '0;
   endfunction
   function automatic logic [37:0] sense_exp();
      logic [23:0] p;
      p = x_o | (~x_oe & ext);
      return {p, alt ? {p[17], p[12:10], p[23]} : {p[6:5], p[16:15], p[3]},
         p[4:0], p[21:20], p[14:13]};
   endfunction
   task automatic cmp_drive(logic [47:0] e);
      checked++;
      if ({pad_oe, pad_o & pad_oe} !== e) begin
         num_errors++;
         $display("unexpected at %0t: pad drive, want %h", $time, e);
      end
   endtask
   task automatic cmp_sense(logic [37:0] e);
      checked++;
      if ({g_in, sense, rx, kbd, ta, tb} !== e) begin
         num_errors++;
         $display("unexpected at %0t: sensed levels, want %h", $time, e);
      end
   endtask
   always @(posedge clk_i) begin
      #1;
      quiet++;
      if (dq.size() > 0) cmp_drive(dq.pop_front());
      if (sq.size() > 0 && quiet >= 8) cmp_sense(sq.pop_front());
   end
   // Seven busy cycles, then nine frozen ones for the input filter
   task automatic run(int windows);
      for (int w = 0; w < windows; w++) begin
         for (int c = 0; c < 16; c++) begin
            @(negedge clk_i);
            rst_n <= !(w == 40 && c < 4);
            hold <= c >= 6;
            if (c <= 6) begin
               en <= 22'($urandom);
               ext <= 24'($urandom);
               alt <= 1'($urandom);
            end
            #1;
            build();
            dq.push_back({x_oe, x_o});
            if (c == 6) begin
               quiet = 0;
               sq.push_back(sense_exp());
            end
         end
      end
   endtask
   task automatic wrap_up();
      if (num_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      clk_i = 1'h0;
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      void'($urandom(96526));
      {rst_n, alt, hold, en, ext} = '0;
      num_errors = 0;
      checked = 0;
      quiet = 0;
      repeat (12) @(negedge clk_i);
      run(200);
      repeat (4) @(negedge clk_i);
      wrap_up();
   end
   initial begin
      #(8 * 4000);
      num_errors++;
      wrap_up();
   end
endmodule
